// *** hdl/tspc_defs.vh ***
`ifndef TSPC_DEFS_VH
`define TSPC_DEFS_VH
// register byte offsets
`define TSPC_OFS_CTRL     8'h00
`define TSPC_OFS_STATUS   8'h04
`define TSPC_OFS_ENABLE   8'h08
`define TSPC_OFS_STANDBY_SELECT_EN  8'h0c
`define TSPC_OFS_CAL_ACT  8'h10
`define TSPC_OFS_THRESH   8'h14
`define TSPC_OFS_LED_CFG  8'h18
`define TSPC_OFS_RECAL    8'h1c
`define TSPC_OFS_BASE     8'h20
`define TSPC_OFS_BASE_END 8'h3c
// control bits
`define TSPC_CTRL_STANDBY_SELECT    0
`define TSPC_CTRL_DSLP    1
`define TSPC_CTRL_INT     2
// status fields
`define TSPC_ST_RESET     8
`define TSPC_ST_PWR_LO    9
`define TSPC_ST_TMPWAKE   11
// led config fields
`define TSPC_LED_LINK     0
`define TSPC_LED_HOST     2
`define TSPC_LED_IDLE     4
`define TSPC_LED_ALERT    6
// reset values
`define TSPC_RST_ENABLE   8'hff
`define TSPC_RST_STANDBY_SELECT_EN  8'h01
`define TSPC_RST_THRESH   16'h0040
`define TSPC_RST_LED_CFG  8'h03
`define TSPC_RST_RECAL    16'h0010
// power states
`define TSPC_PWR_ACTIVE   2'h0
`define TSPC_PWR_STANDBY_SELECT     2'h1
`define TSPC_PWR_DSLP     2'h2
// timing
`define TSPC_CAL_TIME_MS  200
`define TSPC_CLK_KHZ      25000
`define TSPC_AVG_SHIFT    6
`endif

// *** hdl/tspc_top.v ***
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tspc_defs.vh"

// Functional notes
// - power state chosen from standby and deep-sleep select bits.
// - on power change, touches of no-longer-active inputs are cleared.
// - standby measures subset, interrupts, talks, leaves when standby bit clears.
// - deep sleep: no measurement, LEDs static at idle level, no modulation.
// - bus traffic in deep sleep wakes only temporarily; select bit stays set.
// - wake pin high in deep sleep without four-wire mode exits deep sleep.
// - reset pin high holds logic reset except channel pointers and stored averages, no LEDs, defaults restored.
// - reset pin release leaves deep sleep, sets reset status, raises interrupt.
// - four-wire mode never drives the wake pin.
// - standby without four-wire drives wake high until interrupt is cleared.
// - each input has its own enable for the sensing cycle.
// - cycles run back to back, enabled inputs in ascending order.
// - measurement minus baseline at or above threshold means touch and interrupt.
// - every recalibration reloads the per-input baseline.
// - leaving standby recalibrates disabled inputs; deep-sleep wake recalibrates all.
// - calibration activate bit forces recalibration and self-clears.
// - manual recalibration blocks presses; a press restarts it.
// - periodic recalibration from the average of 64 measurements.
// - automatic recalibration only below threshold, never during touch.
// - each LED follows its input when linked, else the host.
// - unlinked host-actuated LED may assert alert when its behaviour completes.
module tspc_top #(
	parameter        MW       = 16,
	parameter [22:0] CAL_CYC  = `TSPC_CAL_TIME_MS * `TSPC_CLK_KHZ
) (
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          hsel,
	input  wire [31:0]   haddr,
	input  wire [1:0]    htrans,
	input  wire          hwrite,
	input  wire [2:0]    hsize,
	input  wire [31:0]   hwdata,
	input  wire          hready,
	output wire          hreadyout,
	output reg  [31:0]   hrdata,
	output wire          hresp,
	input  wire          reset_pin,
	input  wire          spi4_mode,
	input  wire          bus_traffic,
	input  wire          wake_in,
	output reg           wake_out,
	output reg           wake_oe,
	output reg           meas_req,
	output reg  [2:0]    meas_chan,
	input  wire [MW-1:0] meas_data,
	input  wire          meas_valid,
	output reg  [1:0]    led_actuate,
	output reg           led_drive_en,
	output reg           led_pwm_en,
	output reg  [1:0]    led_idle_level,
	input  wire [1:0]    led_done,
	output reg           alert_n
);
	localparam S_PICK = 2'h0;
	localparam S_REQ  = 2'h1;
	localparam S_WAIT = 2'h2;

	// pins pass two flops before any logic reads them
	reg [1:0] rst_s_q, spi4_s_q, bus_s_q, wake_s_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_s_q  <= 2'h3;
			spi4_s_q <= 2'h0;
			bus_s_q  <= 2'h0;
			wake_s_q <= 2'h0;
		end else begin
			rst_s_q  <= {rst_s_q[0], reset_pin};
			spi4_s_q <= {spi4_s_q[0], spi4_mode};
			bus_s_q  <= {bus_s_q[0], bus_traffic};
			wake_s_q <= {wake_s_q[0], wake_in};
		end
	end
	wire hold = rst_s_q[1];
	wire spi4 = spi4_s_q[1];

	reg          standby_select_q, dslp_q, int_q, rstst_q, hold_q, alert_q;
	reg [7:0]    touch_q, en_q, sen_q, cal_q, calbad_q, reload_q, led_q;
	reg [15:0]   thr_q, rate_q, rcnt_q;
	reg [22:0]   ctim_q;
	reg [1:0]    pwr_q, st_q;
	reg [2:0]    ch_q;
	reg [MW-1:0] base_q [0:7];
	reg [MW-1:0] avg_q  [0:7];
	reg [MW+5:0] acc_q  [0:7];
	reg [5:0]    acnt_q [0:7];
	reg [7:0]    avgv_q;

	// ahb-lite address phase capture
	reg       wr_q;
	reg [7:0] wa_q;
	wire      take = hsel & htrans[1] & hready;
	wire      wen  = wr_q & ~hold;
	// zero wait: every register answers in the cycle after its address phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	function wr_hit;
		input [7:0] ofs;
		begin
			wr_hit = wen && (wa_q == ofs);
		end
	endfunction

	// lowest set bit at or above from; gives back from when none is set
	function [2:0] next_chan;
		input [7:0] mask;
		input [2:0] from;
		integer k;
		reg     found;
		begin
			found     = 1'b0;
			next_chan = from;
			for (k = 0; k < 8; k = k + 1) begin
				if (!found && mask[k] && k[2:0] >= from) begin
					next_chan = k[2:0];
					found     = 1'b1;
				end
			end
		end
	endfunction

	// power state: deep sleep over standby
	wire [1:0] pwr_d = dslp_q ? `TSPC_PWR_DSLP : standby_select_q ? `TSPC_PWR_STANDBY_SELECT : `TSPC_PWR_ACTIVE;
	wire [7:0] act_m = (pwr_d == `TSPC_PWR_DSLP) ? 8'h00 :
		(pwr_d == `TSPC_PWR_STANDBY_SELECT) ? (en_q & sen_q) : en_q;
	wire       pwr_chg = (pwr_d != pwr_q);
	wire       cal_on  = (ctim_q != 23'h0);

	// measurement arithmetic for the current channel
	wire [MW-1:0] base_c = base_q[ch_q];
	wire [MW:0]   diff   = {1'b0, meas_data} - {1'b0, base_c};
	// a reading below the baseline never counts as a touch
	wire          over   = ~diff[MW] && (diff[MW-1:0] >= thr_q[MW-1:0]);
	wire          got    = (st_q == S_WAIT) && meas_valid;
	wire          in_cal = cal_q[ch_q] & cal_on;
	// an answer still in flight for a channel that just left the mask raises nothing
	wire          tset   = got && over && !in_cal && !reload_q[ch_q] &&
		act_m[ch_q];
	wire          cal_press = got && in_cal && over;
	// the newest sample is folded in before the shift, so all 64 are averaged
	wire [MW+5:0] acc_n  = (acnt_q[ch_q] == 6'h00) ? {6'h00, meas_data} :
		acc_q[ch_q] + {6'h00, meas_data};
	wire [7:0]    tbit   = tset ? (8'h01 << ch_q) : 8'h00;
	wire          rate_hit = (rcnt_q >= rate_q);
	// only a zero written to the flag clears it; a one leaves it alone
	wire          int_clr  = wr_hit(`TSPC_OFS_CTRL) && !hwdata[`TSPC_CTRL_INT];
	wire          rel      = hold_q && !hold;

	integer i;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			standby_select_q <= 1'b0;
			dslp_q <= 1'b1;
			int_q <= 1'b0;
			rstst_q <= 1'b0;
			hold_q <= 1'b1;
			alert_q <= 1'b0;
			touch_q <= 8'h00;
			en_q <= `TSPC_RST_ENABLE;
			sen_q <= `TSPC_RST_STANDBY_SELECT_EN;
			cal_q <= 8'h00;
			calbad_q <= 8'h00;
			reload_q <= 8'hff;
			led_q <= `TSPC_RST_LED_CFG;
			thr_q <= `TSPC_RST_THRESH;
			rate_q <= `TSPC_RST_RECAL;
			rcnt_q <= 16'h0000;
			ctim_q <= 23'h0;
			pwr_q <= `TSPC_PWR_DSLP;
			st_q <= S_PICK;
			ch_q <= 3'h0;
			avgv_q <= 8'h00;
			meas_req <= 1'b0;
			meas_chan <= 3'h0;
			for (i = 0; i < 8; i = i + 1) begin
				base_q[i] <= {MW{1'b0}};
				avg_q[i]  <= {MW{1'b0}};
				acc_q[i]  <= {(MW+6){1'b0}};
				acnt_q[i] <= 6'h00;
			end
		end else if (hold) begin
			// pin reset: defaults, held in deep sleep, bus ignored
			// channel pointers are left alone; the sequencer restarts from pick anyway
			wr_q <= 1'b0;
			hrdata <= 32'h0000_0000;
			standby_select_q <= 1'b0;
			dslp_q <= 1'b1;
			int_q <= 1'b0;
			rstst_q <= 1'b0;
			hold_q <= 1'b1;
			alert_q <= 1'b0;
			touch_q <= 8'h00;
			en_q <= `TSPC_RST_ENABLE;
			sen_q <= `TSPC_RST_STANDBY_SELECT_EN;
			cal_q <= 8'h00;
			calbad_q <= 8'h00;
			reload_q <= 8'hff;
			led_q <= `TSPC_RST_LED_CFG;
			thr_q <= `TSPC_RST_THRESH;
			rate_q <= `TSPC_RST_RECAL;
			rcnt_q <= 16'h0000;
			ctim_q <= 23'h0;
			pwr_q <= `TSPC_PWR_DSLP;
			st_q <= S_PICK;
			meas_req <= 1'b0;
			avgv_q <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				base_q[i] <= {MW{1'b0}};
				acnt_q[i] <= 6'h00;
				acc_q[i]  <= {(MW+6){1'b0}};
			end
		end else begin
			hold_q <= 1'b0;
			wr_q <= take & hwrite;
			wa_q <= haddr[7:0];
			if (take && !hwrite) begin
				case (haddr[7:0])
				`TSPC_OFS_CTRL:    hrdata <= {29'h0, int_q, dslp_q, standby_select_q};
				`TSPC_OFS_STATUS:  hrdata <= {20'h0, dslp_q & bus_s_q[1], pwr_q, rstst_q, touch_q};
				`TSPC_OFS_ENABLE:  hrdata <= {24'h0, en_q};
				`TSPC_OFS_STANDBY_SELECT_EN: hrdata <= {24'h0, sen_q};
				`TSPC_OFS_CAL_ACT: hrdata <= {24'h0, cal_q};
				`TSPC_OFS_THRESH:  hrdata <= {16'h0, thr_q};
				`TSPC_OFS_LED_CFG: hrdata <= {24'h0, led_q};
				`TSPC_OFS_RECAL:   hrdata <= {16'h0, rate_q};
				default: begin
					if (haddr[7:0] >= `TSPC_OFS_BASE && haddr[7:0] <= `TSPC_OFS_BASE_END)
						hrdata <= {{(32-MW){1'b0}}, base_q[haddr[4:2]]};
					else
						hrdata <= 32'h0000_0000;
				end
				endcase
			end
			// bus traffic only wakes briefly; the select bit is not touched
			if (wr_hit(`TSPC_OFS_CTRL)) begin
				standby_select_q <= hwdata[`TSPC_CTRL_STANDBY_SELECT];
				dslp_q <= hwdata[`TSPC_CTRL_DSLP];
			end else if (rel) begin
				dslp_q <= 1'b0;
			end else if (dslp_q && !spi4 && wake_s_q[1]) begin
				dslp_q <= 1'b0;
			end
			if (wr_hit(`TSPC_OFS_ENABLE))
				en_q <= hwdata[7:0];
			if (wr_hit(`TSPC_OFS_STANDBY_SELECT_EN))
				sen_q <= hwdata[7:0];
			if (wr_hit(`TSPC_OFS_THRESH))
				thr_q <= hwdata[15:0];
			if (wr_hit(`TSPC_OFS_RECAL))
				rate_q <= hwdata[15:0];
			if (wr_hit(`TSPC_OFS_LED_CFG))
				led_q <= hwdata[7:0];
			// flags: a set in the same cycle beats the clear
			int_q   <= (int_q & ~int_clr) | tset | rel;
			rstst_q <= (rstst_q & ~int_clr) | rel;
			touch_q <= ((touch_q & ~{8{int_clr}}) & (pwr_chg ? act_m : 8'hff)) | tbit;
			// alert stands until the host rewrites the led setup, which acknowledges it
			alert_q <= (alert_q & ~wr_hit(`TSPC_OFS_LED_CFG)) |
				|(led_done & ~led_q[1:0] & led_q[3:2] & led_q[7:6]);
			pwr_q <= pwr_d;
			// state-change recalibration
			if (pwr_chg && pwr_q == `TSPC_PWR_STANDBY_SELECT)
				reload_q <= reload_q | ~(en_q & sen_q);
			else if (pwr_chg && pwr_q == `TSPC_PWR_DSLP)
				reload_q <= 8'hff;
			else if (got)
				reload_q <= reload_q & ~(8'h01 << ch_q);
			// manual calibration window; a press restarts it
			if (wr_hit(`TSPC_OFS_CAL_ACT) && hwdata[7:0] != 8'h00) begin
				cal_q <= cal_q | hwdata[7:0];
				calbad_q <= 8'h00;
				ctim_q <= CAL_CYC;
				// a press in the very last cycle still spoils the window
			end else if (ctim_q == 23'h1 && (calbad_q != 8'h00 || cal_press)) begin
				calbad_q <= 8'h00;
				ctim_q <= CAL_CYC;
			end else if (ctim_q == 23'h1) begin
				cal_q <= 8'h00;
				ctim_q <= 23'h0;
			end else begin
				if (cal_on)
					ctim_q <= ctim_q - 23'h1;
				if (cal_press)
					calbad_q <= calbad_q | (8'h01 << ch_q);
			end
			if (cal_q != 8'h00 && !cal_on)
				ctim_q <= CAL_CYC;
			// sensing sequencer
			meas_req <= 1'b0;
			case (st_q)
			S_PICK: begin
				if (act_m != 8'h00) begin
					ch_q <= next_chan(act_m, 3'h0);
					st_q <= S_REQ;
					// counted at cycle start, in step with the averaged-base update below
					rcnt_q <= rate_hit ? 16'h0000 : rcnt_q + 16'h0001;
				end
			end
			S_REQ: begin
				meas_req <= 1'b1;
				meas_chan <= ch_q;
				st_q <= S_WAIT;
			end
			S_WAIT: begin
				if (meas_valid) begin
					// a channel dropped from the mask is simply skipped
					if (ch_q != 3'h7 && (act_m & ~((8'h02 << ch_q) - 8'h01)) != 8'h00) begin
						ch_q <= next_chan(act_m, ch_q + 3'h1);
						st_q <= S_REQ;
					end else begin
						st_q <= S_PICK;
					end
				end
			end
			default: st_q <= S_PICK;
			endcase
			// baseline updates
			if (got) begin
				if (reload_q[ch_q] || (in_cal && !over)) begin
					base_q[ch_q] <= meas_data;
				end else if (!over && !touch_q[ch_q]) begin
					// running 64-sample average only while untouched
					acc_q[ch_q] <= acc_n;
					acnt_q[ch_q] <= acnt_q[ch_q] + 6'h01;
					if (acnt_q[ch_q] == 6'h3f) begin
						avg_q[ch_q] <= acc_n[MW+`TSPC_AVG_SHIFT-1:`TSPC_AVG_SHIFT];
						avgv_q <= avgv_q | (8'h01 << ch_q);
					end
				end
			end
			// averages land only at a cycle boundary, never mid-cycle
			if (rate_hit && st_q == S_PICK && act_m != 8'h00) begin
				for (i = 0; i < 8; i = i + 1) begin
					if (avgv_q[i] && !touch_q[i] && !cal_q[i])
						base_q[i] <= avg_q[i];
				end
				avgv_q <= 8'h00;
			end
		end
	end

	// pin and LED outputs, all registered
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_out <= 1'b0;
			wake_oe <= 1'b0;
			led_actuate <= 2'h0;
			led_drive_en <= 1'b0;
			led_pwm_en <= 1'b0;
			led_idle_level <= 2'h0;
			alert_n <= 1'b1;
		end else begin
			// only standby without four-wire drives the wake pin
			// in standby wake_in carries our own drive; the deep-sleep exit ignores it then
			wake_oe <= ~hold & ~spi4 & (pwr_d == `TSPC_PWR_STANDBY_SELECT);
			wake_out <= ~hold & int_q;
			led_drive_en <= ~hold;
			led_pwm_en <= ~hold & (pwr_d != `TSPC_PWR_DSLP);
			led_idle_level <= led_q[`TSPC_LED_IDLE+1:`TSPC_LED_IDLE];
			if (hold || pwr_d == `TSPC_PWR_DSLP)
				led_actuate <= 2'h0;
			else
				led_actuate <= (led_q[1:0] & touch_q[1:0]) | (~led_q[1:0] & led_q[3:2]);
			alert_n <= ~(alert_q & ~hold);
		end
	end
endmodule
`default_nettype wire

// *** hdl/tspc_pad.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** sim/tspc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module tspc_chk #(
	parameter [22:0] CAL_CYC = 23'd5000000
) (
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic	hreadyout,
	input wire logic [31:0]	hrdata,
	input wire logic	hresp,
	input wire logic	reset_pin,
	input wire logic	spi4_mode,
	input wire logic	wake_out,
	input wire logic	wake_oe,
	input wire logic	meas_req,
	input wire logic	meas_valid,
	input wire logic	led_drive_en,
	input wire logic [1:0]	led_done,
	input wire logic	alert_n
);
	logic		rd_q;
	logic		pend_q;
	logic [2:0]	cw_q;
	logic [2:0]	dn_q;
	logic [5:0]	rp_q;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// short histories of causes, so a fall may be traced back a few cycles
	always @(posedge hclk) begin
		rd_q <= hsel & htrans[1] & hreadyout & !hwrite;
		pend_q <= hresetn & (meas_req | (pend_q & !meas_valid));
		cw_q <= {cw_q[1:0], hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h00)};
		dn_q <= {dn_q[1:0], |led_done};
		rp_q <= {rp_q[4:0], reset_pin};
	end
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus not zero-wait okay");
	property p_spi4; spi4_mode[*5] |-> !wake_oe; endproperty
	a_spi4: assert property (p_spi4) else $error("wake driven in four-wire mode");
	property p_quiet; reset_pin[*5] |-> !led_drive_en && !meas_req; endproperty
	a_quiet: assert property (p_quiet) else $error("activity in pin reset");
	property p_rd0; reset_pin[*5] ##0 rd_q |-> hrdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read not zero in pin reset");
	property p_pend; meas_req |-> !pend_q; endproperty
	a_pend: assert property (p_pend) else $error("request while one pending");
	property p_gap; meas_valid |=> !meas_req; endproperty
	a_gap: assert property (p_gap) else $error("request right after answer");
	property p_wake; $fell(wake_out) |-> (|cw_q) || (|rp_q); endproperty
	a_wake: assert property (p_wake) else $error("wake fell without clear");
	property p_alert; $fell(alert_n) |-> |dn_q; endproperty
	a_alert: assert property (p_alert) else $error("alert without done");
endmodule
bind tspc_top tspc_chk #(.CAL_CYC(CAL_CYC)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hreadyout, .hrdata, .hresp, .reset_pin, .spi4_mode, .wake_out, .wake_oe,
	.meas_req, .meas_valid, .led_drive_en, .led_done, .alert_n);
`default_nettype wire

// *** sim/tspc_sense_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tspc_sense_model (
	input wire logic	hclk,
	input wire logic	meas_req,
	input wire logic [2:0]	meas_chan,
	input wire logic [15:0]	base,
	input wire logic [7:0]	touch,
	output logic		meas_valid,
	output logic [15:0]	meas_data
);
	logic [1:0]	cnt_q;
	logic		slow_q;
	logic [2:0]	ch_q;
	initial begin
		{meas_valid, meas_data, cnt_q, slow_q, ch_q} = '0;
	end
	// alternate prompt and slow answers; data toggles when not answering
	always @(posedge hclk) begin
		meas_valid <= 1'b0;
		meas_data <= ~meas_data;
		if (meas_req) begin
			cnt_q <= slow_q ? 2'h3 : 2'h1;
			slow_q <= ~slow_q;
			ch_q <= meas_chan;
		end else if (cnt_q != 2'h0) begin
			cnt_q <= cnt_q - 2'h1;
			meas_valid <= cnt_q == 2'h1;
			meas_data <= base + {7'h0, touch[ch_q], 8'h0};
		end
	end
endmodule
`default_nettype wire

// *** sim/touch_sense_power_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_sense_power_control_tb;
	logic		hclk, hresetn, hsel, hwrite, reset_pin, spi4_mode, bus_traffic, wk_ext;
	logic [1:0]	htrans, led_done;
	logic [31:0]	haddr, hwdata;
	logic [15:0]	base;
	logic [7:0]	touch;
	wire		hreadyout, hresp, wake_in, wake_out, wake_oe, meas_req, meas_valid;
	wire		led_drive_en, led_pwm_en, alert_n;
	wire [31:0]	hrdata;
	wire [15:0]	meas_data;
	wire [2:0]	meas_chan;
	wire [1:0]	led_actuate, led_idle_level;
	int		errors, checks_done, cyc, nreq, n;
	logic [7:0]	ofs [6] = '{8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h40};
	logic [31:0]	dfl [6] = '{32'hff, 32'h1, 32'h40, 32'h3, 32'h10, 32'h0};
	assign wake_in = wake_oe ? wake_out : wk_ext; // follows wk_ext when undriven
	tspc_top #(.MW(16), .CAL_CYC(23'd100)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.reset_pin, .spi4_mode, .bus_traffic, .wake_in, .wake_out, .wake_oe, .meas_req,
		.meas_chan, .meas_data, .meas_valid, .led_actuate, .led_drive_en, .led_pwm_en,
		.led_idle_level, .led_done, .alert_n);
	tspc_sense_model model (.hclk, .meas_req, .meas_chan, .base, .touch, .meas_valid,
		.meas_data);
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		nreq += meas_req;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end
	task automatic w(input int c);
		repeat (c) @(posedge hclk);
	endtask
	task automatic cmpr(input string s, input logic [31:0] e, input logic [31:0] v);
		checks_done++;
		if (v !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask
	// the value is taken at the call: callers step to a falling edge first
	task automatic cmpp(input string s, input logic e, input logic v);
		checks_done++;
		if (v !== e) begin
			errors++;
			$display("mismatch %s expected %b seen %b", s, e, v);
		end
	endtask
	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr_en;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmpr($sformatf("reg %h", a), e, q);
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{hsel, hwrite, spi4_mode, bus_traffic, wk_ext, reset_pin, hresetn} = '0;
		{htrans, led_done, haddr, hwdata, touch} = '0;
		base = 16'h1000;
		w(4);
		hresetn <= 1'b1;
		w(8);
		rd(8'h00, 32'h4);
		rd(8'h04, 32'h100);
		for (int i = 0; i < 6; i++)
			rd(ofs[i], dfl[i]);
		wr(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		$display("test reset end");
		touch <= 8'h06;
		w(100);
		rd(8'h04, 32'h6);
		rd(8'h00, 32'h4);
		rd(8'h28, 32'h1000);
		@(negedge hclk);
		cmpp("led_actuate", 1'b1, led_actuate[1]);
		w(1);
		touch <= 8'h00;
		w(100);
		rd(8'h04, 32'h6);
		wr(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'h08, 32'hfb);
		touch <= 8'h04;
		w(100);
		rd(8'h04, 32'h0);
		touch <= 8'h00;
		wr(8'h08, 32'hff);
		$display("test touch end");
		wr(8'h00, 32'h1);
		touch <= 8'h09;
		w(100);
		rd(8'h04, 32'h201);
		@(negedge hclk);
		cmpp("wake_out", 1'b1, wake_out);
		cmpp("wake_oe", 1'b1, wake_oe);
		cmpr("meas_chan", 32'h0, {29'h0, meas_chan});
		w(1);
		{touch, base} <= {8'h00, 16'h1020};
		w(100);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1);
		@(negedge hclk);
		cmpp("wake_out", 1'b0, wake_out);
		w(1);
		spi4_mode <= 1'b1;
		w(8);
		@(negedge hclk);
		cmpp("wake_oe", 1'b0, wake_oe);
		w(1);
		spi4_mode <= 1'b0;
		wr(8'h00, 32'h0);
		w(100);
		rd(8'h34, 32'h1020);
		$display("test standby end");
		wr(8'h00, 32'h2);
		base <= 16'h1030;
		w(10);
		n = nreq;
		w(100);
		rd(8'h04, 32'h400);
		cmpr("meas_req count", n, nreq);
		@(negedge hclk);
		cmpp("led_pwm_en", 1'b0, led_pwm_en);
		w(1);
		bus_traffic <= 1'b1;
		w(4);
		rd(8'h04, 32'hc00);
		bus_traffic <= 1'b0;
		{spi4_mode, wk_ext} <= 2'h3;
		w(8);
		rd(8'h00, 32'h2);
		spi4_mode <= 1'b0;
		w(8);
		rd(8'h00, 32'h0);
		wk_ext <= 1'b0;
		w(100);
		rd(8'h3c, 32'h1030);
		$display("test deep sleep end");
		base <= 16'h1038;
		wr(8'h10, 32'h2);
		rd(8'h10, 32'h2);
		w(200);
		rd(8'h10, 32'h0);
		rd(8'h24, 32'h1038);
		$display("test calibrate end");
		wr(8'h18, 32'h64);
		w(1);
		@(negedge hclk);
		cmpp("led_actuate", 1'b1, led_actuate[0]);
		cmpr("led_idle_level", 32'h2, {30'h0, led_idle_level});
		w(1);
		led_done <= 2'h1;
		w(1);
		led_done <= 2'h0;
		w(3);
		@(negedge hclk);
		cmpp("alert_n", 1'b0, alert_n);
		wr(8'h18, 32'h3);
		w(3);
		@(negedge hclk);
		cmpp("alert_n", 1'b1, alert_n);
		$display("test led end");
		w(1);
		reset_pin <= 1'b1;
		w(6);
		rd(8'h08, 32'h0);
		@(negedge hclk);
		cmpp("led_drive_en", 1'b0, led_drive_en);
		w(1);
		reset_pin <= 1'b0;
		w(6);
		rd(8'h00, 32'h4);
		rd(8'h04, 32'h100);
		rd(8'h18, 32'h3);
		$display("test pin reset end");
		complete_run();
	end
endmodule
`default_nettype wire
